// File: design/sfep_pkg.sv
package sfep_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 20;
    localparam int unsigned DATA_W         = 64;
    localparam int unsigned CHK_W          = 8;
    localparam int unsigned ADDR_W         = 16;
    localparam int unsigned HALF_W         = 32;
    localparam int unsigned START_NS       = 20;
    localparam int unsigned MSEL_FAST_NS   = 6;
    localparam int unsigned MSEL_SLOW_NS   = 8;
    localparam int unsigned LATCH_NS       = 80;
    localparam int unsigned NDG_SET_NS     = 100;
    localparam int unsigned NDG_CLR_NS     = 150;
    localparam int unsigned SYND_NS        = 170;
    localparam int unsigned VALID_NS       = 237;
    localparam int unsigned WRITE_NS       = 210;
    // Least times round up, and nothing comes to less than one cycle
    localparam int unsigned START_CYC  = (START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MSEL_F_CYC = START_CYC + (MSEL_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MSEL_S_CYC = START_CYC + (MSEL_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LATCH_CYC  = START_CYC + (LATCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned NDG_S_CYC  = START_CYC + (NDG_SET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned NDG_C_CYC  = START_CYC + (NDG_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SYND_CYC   = START_CYC + (SYND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned VALID_CYC  = START_CYC + (VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WRITE_CYC  = START_CYC + (WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DONE_CYC   = WRITE_CYC + 1;
    localparam int unsigned TMR_W      = 5;
    // Machine-check byte 2 fields and the byte 0 address bit
    localparam int unsigned MC2_HDW_BIT   = 4;
    localparam int unsigned MC2_DATA_BIT  = 5;
    localparam int unsigned MC2_CHK_BIT   = 6;
    localparam int unsigned MC2_DBL_BIT   = 7;
    localparam int unsigned MC0_ADDR_BIT  = 0;
    localparam logic [7:0]  MC_RESET      = 8'h00;
    // Syndrome column codes select bit position within data word
    localparam logic [6:0]  SYN_ZERO      = 7'h00;
    // Syndrome left by a flip of data bit 0: lowest odd-weight code of three bits
    localparam logic [CHK_W-1:0] SYN_DATA0 = 8'h07;

    typedef struct packed {
        logic             sel;
        logic             wr;
        logic             ctrl_store;
        logic             diag_parity;
        logic [ADDR_W-1:0] addr;
        logic             addr_par;
    } sfep_req_type;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [7:0]        par;
        logic              valid;
        logic              not_good;
        logic [7:0]        mc_byte0;
        logic [7:0]        mc_byte2;
        logic [7:0]        mc_byte3;
    } sfep_rsp_type;

    typedef enum logic [5:0] {
        SFEP_IDLE  = 6'b000001,
        SFEP_START = 6'b000010,
        SFEP_READ  = 6'b000100,
        SFEP_CHECK = 6'b001000,
        SFEP_WRITE = 6'b010000,
        SFEP_DONE  = 6'b100000
    } sfep_state_type;
endpackage : sfep_pkg

// File: design/sfep_store.sv
`timescale 1ns/1ns
`default_nettype none
module sfep_store
    import sfep_pkg::*;
#(
    parameter int unsigned AW = 4
)
(
    input  wire logic              ref_clk,
    input  wire logic              we,
    input  wire logic [AW-1:0]     waddr,
    input  wire logic [HALF_W-1:0] wdata,
    input  wire logic [3:0]        wchk,
    input  wire logic [AW-1:0]     raddr,
    output logic      [HALF_W-1:0] rdata,
    output logic      [3:0]        rchk
);
    if (AW < 1 || AW > 12)
    begin : g_bad_aw
        $error("sfep_store: AW out of range");
    end

    // Array contents have no reset; check bits always travel with data
    logic [HALF_W+3:0] mem [0:(1<<AW)-1];
    logic [HALF_W+3:0] rd_q;

    always_ff @(posedge ref_clk)
    begin
        if (we)
            mem[waddr] <= {wchk, wdata};
        rd_q <= mem[raddr];
    end

    assign rdata = rd_q[HALF_W-1:0];
    assign rchk  = rd_q[HALF_W+3:HALF_W];
endmodule : sfep_store
`default_nettype wire

// File: design/sfep_top.sv
`timescale 1ns/1ns
`default_nettype none
module sfep_top
    import sfep_pkg::*;
#(
    parameter int unsigned STORE_AW  = 4,
    parameter bit          SLOW_ABUF = 1'b0
)
(
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire sfep_req_type      req,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [7:0]        wr_byte_en,
    input  wire logic [7:0]        inject_flip,
    input  wire logic              inject_gen_fault,
    output sfep_rsp_type           rsp,
    output logic                   module_select,
    output logic                   busy
);
    if (STORE_AW < 1 || STORE_AW > 12 || STORE_AW > ADDR_W - 1)
    begin : g_bad_store_aw
        $error("sfep_top: STORE_AW out of range");
    end

    localparam int unsigned MSEL_CYC = SLOW_ABUF ? MSEL_S_CYC : MSEL_F_CYC;

    // Data columns are the odd-weight codes of three or more bits, in order;
    // a check-bit flip gives weight one, so no single error aliases another
    function automatic logic [CHK_W-1:0] data_col(input int unsigned idx);
        logic [CHK_W-1:0] col;
        int unsigned      seen;
        col  = '0;
        seen = 0;
        for (int v = 0; v < (1 << CHK_W); v++)
        begin
            if ($countones(v) % 2 == 1 && $countones(v) >= 3)
            begin
                if (seen == idx)
                    col = CHK_W'(v);
                seen++;
            end
        end
        return col;
    endfunction : data_col

    function automatic logic [CHK_W-1:0] gen_check(input logic [DATA_W-1:0] d);
        logic [CHK_W-1:0] c;
        c = '0;
        for (int unsigned i = 0; i < DATA_W; i++)
            if (d[i])
                c = c ^ data_col(i);
        return c;
    endfunction : gen_check

    function automatic logic [7:0] byte_par(input logic [DATA_W-1:0] d);
        logic [7:0] p;
        p = 8'h00;
        for (int b = 0; b < 8; b++)
            p[b] = ^d[b*8 +: 8];
        return p;
    endfunction : byte_par

    // Search keeps the decoder tied to the column table; 7f means no data bit
    function automatic logic [6:0] find_bit(input logic [CHK_W-1:0] s);
        logic [6:0] hit;
        hit = 7'h7f;
        for (int unsigned i = 0; i < DATA_W; i++)
            if (data_col(i) == s && hit == 7'h7f)
                hit = 7'(i);
        return hit;
    endfunction : find_bit

    sfep_state_type       state_q, state_d;
    logic [TMR_W-1:0]     tmr_q, tmr_d;
    logic                 wr_q, wr_d;
    logic                 cs_q, cs_d;
    logic                 diag_q, diag_d;
    logic [ADDR_W-1:0]    addr_q, addr_d;
    logic [DATA_W-1:0]    out_q, out_d;
    logic [DATA_W-1:0]    stl_q, stl_d;
    logic [CHK_W-1:0]     schk_q, schk_d;
    logic [CHK_W-1:0]     syn_q, syn_d;
    logic                 ovp_q, ovp_d;
    logic [7:0]           par_q, par_d;
    logic                 valid_q, valid_d;
    logic                 ndg_q, ndg_d;
    logic                 msel_q, msel_d;
    logic [7:0]           mc0_q, mc0_d;
    logic [7:0]           mc2_q, mc2_d;
    logic [7:0]           mc3_q, mc3_d;
    logic                 hold_q, hold_d;

    logic [HALF_W-1:0]    up_rdata, lo_rdata;
    logic [3:0]           up_rchk, lo_rchk;
    logic                 st_we;
    logic [DATA_W-1:0]    merged;
    logic [CHK_W-1:0]     rd_gen, wr_gen, syn_now;
    logic [7:0]           rd_par;
    logic                 ovp_now;
    logic [6:0]           bad_bit;

    // Upper module holds the high word, lower the low word
    sfep_store #(.AW(STORE_AW)) u_upper (
        .ref_clk (ref_clk),
        .we      (st_we),
        .waddr   (addr_q[STORE_AW-1:0]),
        .wdata   (merged[DATA_W-1:HALF_W]),
        .wchk    (wr_gen[7:4]),
        .raddr   (addr_q[STORE_AW-1:0]),
        .rdata   (up_rdata),
        .rchk    (up_rchk)
    );

    sfep_store #(.AW(STORE_AW)) u_lower (
        .ref_clk (ref_clk),
        .we      (st_we),
        .waddr   (addr_q[STORE_AW-1:0]),
        .wdata   (merged[HALF_W-1:0]),
        .wchk    (wr_gen[3:0]),
        .raddr   (addr_q[STORE_AW-1:0]),
        .rdata   (lo_rdata),
        .rchk    (lo_rchk)
    );

    // Merge new bytes over the corrected old word for the write half
    always_comb
    begin
        merged = out_q;
        for (int b = 0; b < 8; b++)
            if (wr_byte_en[b])
                merged[b*8 +: 8] = wr_data[b*8 +: 8];
    end

    assign st_we   = (state_q == SFEP_WRITE);
    assign rd_gen  = gen_check(stl_q);
    // Write generator sees the same data through the write switches on reads
    assign wr_gen  = state_q == SFEP_WRITE ? gen_check(merged) :
                     gen_check(stl_q) ^ {7'h00, inject_gen_fault};
    assign rd_par  = byte_par(stl_q);
    assign syn_now = schk_q ^ rd_gen;
    // Overall parity: stored check parity against generated check parity; the byte and data parity terms cancel
    assign ovp_now = (^schk_q) ^ (^rd_gen) ^ (^rd_par) ^ (^stl_q);
    assign bad_bit = find_bit(syn_q);

    always_comb
    begin
        state_d = state_q;
        tmr_d   = tmr_q;
        wr_d    = wr_q;
        cs_d    = cs_q;
        diag_d  = diag_q;
        addr_d  = addr_q;
        out_d   = out_q;
        stl_d   = stl_q;
        schk_d  = schk_q;
        syn_d   = syn_q;
        ovp_d   = ovp_q;
        par_d   = par_q;
        valid_d = 1'b0;
        ndg_d   = ndg_q;
        msel_d  = 1'b0;
        mc0_d   = mc0_q;
        mc2_d   = mc2_q;
        mc3_d   = mc3_q;
        hold_d  = hold_q;
        if (state_q != SFEP_IDLE)
            tmr_d = tmr_q + 5'(1);
        unique case (state_q)
            SFEP_IDLE:
            begin
                if (req.sel)
                begin
                    state_d = SFEP_START;
                    tmr_d   = 5'h00;
                    wr_d    = req.wr;
                    cs_d    = req.ctrl_store;
                    diag_d  = req.diag_parity;
                    addr_d  = req.addr;
                    mc0_d   = MC_RESET;
                    mc2_d   = MC_RESET;
                    mc3_d   = MC_RESET;
                    hold_d  = 1'b0;
                    mc0_d[MC0_ADDR_BIT] = (^req.addr) ^ req.addr_par;
                end
            end
            SFEP_START:
            begin
                if (tmr_q == 5'(START_CYC - 1))
                    state_d = SFEP_READ;
            end
            SFEP_READ:
            begin
                if (tmr_q == 5'(MSEL_CYC - 1))
                    msel_d = 1'b1;
                if (tmr_q == 5'(LATCH_CYC - 1))
                begin
                    out_d   = {up_rdata, lo_rdata};
                    stl_d   = {up_rdata, lo_rdata};
                    schk_d  = {up_rchk, lo_rchk} ^ inject_flip;
                    par_d   = byte_par({up_rdata, lo_rdata});
                    state_d = SFEP_CHECK;
                end
            end
            SFEP_CHECK:
            begin
                if (rd_gen != wr_gen)
                    mc2_d[MC2_HDW_BIT] = 1'b1;
                if (cs_q && tmr_q == 5'(NDG_S_CYC - 1))
                    ndg_d = 1'b1;
                if (cs_q && tmr_q == 5'(NDG_C_CYC - 1) && syn_now == 8'h00)
                    ndg_d = 1'b0;
                if (cs_q && tmr_q == 5'(NDG_C_CYC - 1) && syn_now != 8'h00)
                    hold_d = 1'b1;
                if (tmr_q == 5'(SYND_CYC - 1))
                begin
                    syn_d = syn_now;
                    ovp_d = ovp_now;
                    mc3_d = syn_now;
                    if (syn_now != 8'h00 && !ovp_now)
                        mc2_d[MC2_DBL_BIT] = 1'b1;
                    else if (syn_now != 8'h00 && find_bit(syn_now) == 7'h7f)
                        mc2_d[MC2_CHK_BIT] = 1'b1;
                    else if (syn_now != 8'h00)
                        mc2_d[MC2_DATA_BIT] = 1'b1;
                end
                if (tmr_q == 5'(SYND_CYC))
                begin
                    if (mc2_q[MC2_DATA_BIT] && !mc2_q[MC2_DBL_BIT])
                    begin
                        out_d[bad_bit[5:0]]    = ~out_q[bad_bit[5:0]];
                        par_d[bad_bit[5:3]]    = ~par_q[bad_bit[5:3]];
                    end
                end
                if (diag_q && tmr_q == 5'(SYND_CYC))
                    par_d = schk_q;
                if (tmr_q == 5'(VALID_CYC - 1))
                begin
                    valid_d = 1'b1;
                    ndg_d   = 1'b0;
                    hold_d  = 1'b0;
                    state_d = wr_q ? SFEP_WRITE : SFEP_DONE;
                end
            end
            SFEP_WRITE:
            begin
                state_d = SFEP_DONE;
            end
            SFEP_DONE:
            begin
                state_d = SFEP_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= SFEP_IDLE;
            tmr_q   <= 5'h00;
            wr_q    <= 1'b0;
            cs_q    <= 1'b0;
            diag_q  <= 1'b0;
            addr_q  <= '0;
            out_q   <= '0;
            stl_q   <= '0;
            schk_q  <= 8'h00;
            syn_q   <= 8'h00;
            ovp_q   <= 1'b0;
            par_q   <= 8'h00;
            valid_q <= 1'b0;
            ndg_q   <= 1'b0;
            msel_q  <= 1'b0;
            mc0_q   <= MC_RESET;
            mc2_q   <= MC_RESET;
            mc3_q   <= MC_RESET;
            hold_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            tmr_q   <= tmr_d;
            wr_q    <= wr_d;
            cs_q    <= cs_d;
            diag_q  <= diag_d;
            addr_q  <= addr_d;
            out_q   <= out_d;
            stl_q   <= stl_d;
            schk_q  <= schk_d;
            syn_q   <= syn_d;
            ovp_q   <= ovp_d;
            par_q   <= par_d;
            valid_q <= valid_d;
            ndg_q   <= ndg_d;
            msel_q  <= msel_d;
            mc0_q   <= mc0_d;
            mc2_q   <= mc2_d;
            mc3_q   <= mc3_d;
            hold_q  <= hold_d;
        end
    end

    assign rsp.data     = out_q;
    assign rsp.par      = par_q;
    assign rsp.valid    = valid_q;
    assign rsp.not_good = ndg_q;
    assign rsp.mc_byte0 = mc0_q;
    assign rsp.mc_byte2 = mc2_q;
    assign rsp.mc_byte3 = mc3_q;
    assign module_select = msel_q;
    assign busy          = state_q != SFEP_IDLE;

    valid_time_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(busy) |-> ##(VALID_CYC) rsp.valid)
        else $error("valid not at expected cycle");
    msel_time_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(busy) |-> ##(MSEL_CYC) module_select)
        else $error("module select late or early");
    ndg_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(rsp.not_good) |-> cs_q && tmr_q == 5'(NDG_S_CYC))
        else $error("not-good rose at wrong time");
    write_after_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        st_we |-> rsp.valid && wr_q && $past(state_q) == SFEP_CHECK)
        else $error("write without preceding read");
    hold_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (hold_q && tmr_q != 5'(SYND_CYC)) |=> $stable(out_q))
        else $error("output latches moved while held");
    hdw_check_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state_q == SFEP_CHECK && rd_gen != wr_gen) |=> mc2_q[MC2_HDW_BIT])
        else $error("generator mismatch not flagged");
    syn_report_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state_q == SFEP_CHECK && tmr_q == 5'(SYND_CYC - 1)) |=> mc3_q == $past(syn_now))
        else $error("syndrome byte wrong");
    dbl_nocorr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state_q == SFEP_CHECK && mc2_q[MC2_DBL_BIT] && tmr_q == 5'(SYND_CYC)) |=> $stable(out_q))
        else $error("double error altered data");
    addr_par_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state_q == SFEP_IDLE && req.sel && ((^req.addr) != req.addr_par)) |=> mc0_q[MC0_ADDR_BIT])
        else $error("address parity error missed");
endmodule : sfep_top
`default_nettype wire

// File: bench/sfep_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module sfep_cpu_model
    import sfep_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              go,
    input  wire logic              op_wr,
    input  wire logic              op_ctrl,
    input  wire logic              op_diag,
    input  wire logic [ADDR_W-1:0] op_addr,
    input  wire logic              op_bad_par,
    input  wire sfep_rsp_type      rsp,
    input  wire logic              module_select,
    input  wire logic              busy,
    output sfep_req_type           req,
    output logic                   done,
    output logic      [DATA_W-1:0] got_data,
    output var int                 t_msel,
    output var int                 t_valid,
    output var int                 t_ndg_on,
    output var int                 t_ndg_off,
    output var int                 t_end
);
    int   n;
    logic took;
    initial
    begin
        req = '0;
        done = 1'b0;
        got_data = '0;
    end
    always @(posedge ref_clk)
    begin
        if (go && !busy)
        begin
            req.sel <= 1'b1;
            req.wr <= op_wr;
            req.ctrl_store <= op_ctrl;
            req.diag_parity <= op_diag;
            req.addr <= op_addr;
            req.addr_par <= (^op_addr) ^ op_bad_par;
            done <= 1'b0;
            t_msel = 0;
            t_valid = 0;
            t_ndg_on = 0;
            t_ndg_off = 0;
            took = 1'b0;
            n = 0;
            @(posedge ref_clk);
            // Address is not held after select, so a late sample sees junk
            req.sel <= 1'b0;
            req.addr <= ~op_addr;
            do
            begin
                @(posedge ref_clk);
                n++;
                #1;
                if (module_select && t_msel == 0)
                    t_msel = n;
                if (rsp.valid)
                    t_valid = n;
                if (rsp.not_good && t_ndg_on == 0)
                    t_ndg_on = n;
                if (!rsp.not_good && t_ndg_on != 0 && t_ndg_off == 0)
                    t_ndg_off = n;
                // Control data only once not-good has gone, else wait for valid
                if (!took && (rsp.valid || (op_ctrl && t_ndg_off != 0)))
                begin
                    got_data = rsp.data;
                    took = 1'b1;
                end
            end
            while (busy && n < 64);
            t_end = n;
            done <= 1'b1;
        end
    end
endmodule : sfep_cpu_model
`default_nettype wire

// File: bench/tb_sfep_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %0h seen %0h", nm, (e), (g)); end end
module tb_sfep_top
    import sfep_pkg::*;
;
    logic              ref_clk = 1'b0;
    logic              rst_b = 1'b0;
    logic              go = 1'b0;
    logic              op_wr = 1'b0;
    logic              op_ctrl = 1'b0;
    logic              op_diag = 1'b0;
    logic              op_bad_par = 1'b0;
    logic [ADDR_W-1:0] op_addr = '0;
    logic [DATA_W-1:0] wr_data = '0;
    logic [DATA_W-1:0] got_data;
    logic [DATA_W-1:0] ex;
    logic [7:0]        wr_byte_en = 8'h00;
    logic [7:0]        inject_flip = 8'h00;
    logic              inject_gen_fault = 1'b0;
    sfep_req_type      req;
    sfep_rsp_type      rsp;
    logic              module_select;
    logic              busy;
    logic              done;
    int                t_msel;
    int                t_valid;
    int                t_ndg_on;
    int                t_ndg_off;
    int                t_end;
    int                bad_count = 0;
    int                n_checks = 0;

    always #10 ref_clk = ~ref_clk;

    sfep_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .req(req), .wr_data(wr_data),
        .wr_byte_en(wr_byte_en), .inject_flip(inject_flip), .inject_gen_fault(inject_gen_fault),
        .rsp(rsp), .module_select(module_select), .busy(busy));
    sfep_cpu_model u_cpu (.ref_clk(ref_clk), .go(go), .op_wr(op_wr), .op_ctrl(op_ctrl),
        .op_diag(op_diag), .op_addr(op_addr), .op_bad_par(op_bad_par), .rsp(rsp),
        .module_select(module_select), .busy(busy), .req(req), .done(done), .got_data(got_data),
        .t_msel(t_msel), .t_valid(t_valid), .t_ndg_on(t_ndg_on), .t_ndg_off(t_ndg_off), .t_end(t_end));

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    task automatic op(input logic w, input logic c, input logic d, input logic bp);
        int k;
        @(posedge ref_clk);
        op_wr <= w;
        op_ctrl <= c;
        op_diag <= d;
        op_addr <= 16'h0003;
        op_bad_par <= bp;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (!done && k < 100);
        `CHK("op_done", 1'b1, done)
    endtask : op

    task automatic chk_rd();
        `CHK("data", ex, rsp.data)
        for (int i = 0; i < 8; i++)
            `CHK("byte_par", ^ex[8*i+:8], rsp.par[i])
    endtask : chk_rd

    task automatic t_basic();
        int tw;
        wr_data <= 64'h0123_4567_89ab_cdef;
        wr_byte_en <= 8'hff;
        op(1'b1, 1'b0, 1'b0, 1'b0);
        tw = t_end;
        ex = 64'h0123_4567_89ab_cdef;
        op(1'b0, 1'b0, 1'b0, 1'b0);
        `CHK("wr_len", t_end + 1, tw)
        `CHK("msel_cyc", MSEL_F_CYC, t_msel)
        `CHK("valid_cyc", VALID_CYC, t_valid)
        `CHK("got", ex, got_data)
        `CHK("mc2", 8'h00, rsp.mc_byte2)
        `CHK("mc3", 8'h00, rsp.mc_byte3)
        chk_rd();
    endtask : t_basic

    task automatic t_merge();
        wr_data <= 64'hfedc_ba98_7654_3210;
        wr_byte_en <= 8'h0f;
        op(1'b1, 1'b0, 1'b0, 1'b0);
        ex = 64'h0123_4567_7654_3210;
        op(1'b0, 1'b0, 1'b0, 1'b0);
        chk_rd();
    endtask : t_merge

    task automatic t_flips();
        // Only check bits can be corrupted, so data must come back untouched
        for (int i = 0; i < 8; i++)
        begin
            inject_flip <= 8'h01 << i;
            op(1'b0, 1'b0, 1'b0, 1'b0);
            `CHK("mc3_single", 8'h01 << i, rsp.mc_byte3)
            `CHK("mc2_chk", 8'h40, rsp.mc_byte2)
            chk_rd();
        end
        // Check bits equal to data bit 0's column must be taken as that bit
        inject_flip <= SYN_DATA0;
        ex = ex ^ 64'h1;
        op(1'b0, 1'b0, 1'b0, 1'b0);
        `CHK("mc2_data", 8'h20, rsp.mc_byte2)
        `CHK("mc3_data", SYN_DATA0, rsp.mc_byte3)
        chk_rd();
        ex = ex ^ 64'h1;
        inject_flip <= 8'h03;
        op(1'b0, 1'b0, 1'b0, 1'b0);
        `CHK("mc3_dbl", 8'h03, rsp.mc_byte3)
        `CHK("mc2_dbl", 8'h80, rsp.mc_byte2)
        `CHK("dbl_data", ex, rsp.data)
        inject_flip <= 8'h00;
    endtask : t_flips

    task automatic t_hw_addr();
        inject_gen_fault <= 1'b1;
        op(1'b0, 1'b0, 1'b0, 1'b0);
        `CHK("mc2_hw", 8'h10, rsp.mc_byte2)
        inject_gen_fault <= 1'b0;
        op(1'b0, 1'b0, 1'b0, 1'b1);
        `CHK("mc0_addr", 8'h01, rsp.mc_byte0)
        op(1'b0, 1'b0, 1'b0, 1'b0);
        `CHK("mc0_clear", 8'h00, rsp.mc_byte0)
    endtask : t_hw_addr

    task automatic t_diag();
        logic [7:0] p0;
        op(1'b0, 1'b0, 1'b1, 1'b0);
        p0 = rsp.par;
        inject_flip <= 8'h5a;
        op(1'b0, 1'b0, 1'b1, 1'b0);
        `CHK("diag_par", p0 ^ 8'h5a, rsp.par)
        inject_flip <= 8'h00;
    endtask : t_diag

    task automatic t_ctrl();
        op(1'b0, 1'b1, 1'b0, 1'b0);
        `CHK("ndg_on", NDG_S_CYC, t_ndg_on)
        `CHK("ndg_off", NDG_C_CYC, t_ndg_off)
        `CHK("ctrl_data", ex, got_data)
        inject_flip <= 8'h01;
        op(1'b0, 1'b1, 1'b0, 1'b0);
        `CHK("ndg_hold", VALID_CYC, t_ndg_off)
        `CHK("ctrl_fix", ex, got_data)
        inject_flip <= SYN_DATA0;
        op(1'b0, 1'b1, 1'b0, 1'b0);
        `CHK("ctrl_corr", ex ^ 64'h1, got_data)
        inject_flip <= 8'h00;
    endtask : t_ctrl

    initial
    begin
        repeat (5000) @(posedge ref_clk);
        bad_count++;
        give_verdict();
    end

    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_basic();
        t_merge();
        t_flips();
        t_hw_addr();
        t_diag();
        t_ctrl();
        give_verdict();
    end
endmodule : tb_sfep_top
`default_nettype wire
